/* shared/gpmc_pkg.sv */
// Package with register map, field layout and reset values of the GPIO port block
// How it works
// - Mode field: 00 input, 01 output, 10 alternate function, 11 analog.
// - One 32-bit mode register per port, two mode bits for each of sixteen pins.
// - Drive-type bit 0 push-pull, 1 open-drain, only while the pin drives.
// - Pull field 00 none, 01 pull-up, 10 pull-down; ignored in analog mode.
// - In alternate mode the peripheral's output enable sets pad direction.
// - Per-pin speed setting in its own register, applied while the pin drives.
// - Up to 29 pins over three ports; unimplemented positions have no pad.
// - Any pin can carry a peripheral function, input or output.
// - A pin's output level inverts in one bus write, no read-modify-write.
// - Each pin's input level goes to the external line controller; no edge setup here.
// - Pin levels are sampled into input status every clock, except analog mode.
// - Open-drain drives low for output value 0, releases the pad for 1.
package gpmc_pkg;
    localparam int GPMC_PINS = 16;
    localparam int GPMC_PORTS = 3;
    // Register offsets inside each port's 1 KiB window
    localparam logic [9:0] GPMC_OFF_MODE = 10'h000;
    localparam logic [9:0] GPMC_OFF_DRIVE = 10'h004;
    localparam logic [9:0] GPMC_OFF_SPEED = 10'h008;
    localparam logic [9:0] GPMC_OFF_PULL = 10'h00C;
    localparam logic [9:0] GPMC_OFF_INPUT = 10'h010;
    localparam logic [9:0] GPMC_OFF_OUTPUT = 10'h014;
    localparam logic [9:0] GPMC_OFF_SETCLR = 10'h018;
    localparam logic [9:0] GPMC_OFF_TOGGLE = 10'h02C;
    localparam int GPMC_PORT_SEL_LSB = 10;
    // Mode encodings
    localparam logic [1:0] GPMC_MODE_IN = 2'h0;
    localparam logic [1:0] GPMC_MODE_OUT = 2'h1;
    localparam logic [1:0] GPMC_MODE_ALT = 2'h2;
    localparam logic [1:0] GPMC_MODE_ANA = 2'h3;
    // Pull encodings
    localparam logic [1:0] GPMC_PULL_NONE = 2'h0;
    localparam logic [1:0] GPMC_PULL_UP = 2'h1;
    localparam logic [1:0] GPMC_PULL_DOWN = 2'h2;
    // Reset values per port
    localparam logic [31:0] GPMC_MODE_RST_A = 32'hA8000000;
    localparam logic [31:0] GPMC_MODE_RST_B = 32'h00000280;
    localparam logic [31:0] GPMC_MODE_RST_C = 32'h00000000;
    localparam logic [31:0] GPMC_PULL_RST_A = 32'h64000000;
    localparam logic [31:0] GPMC_PULL_RST_B = 32'h00000100;
    localparam logic [31:0] GPMC_PULL_RST_C = 32'h00000000;
    // Implemented pins per port: 16 + 9 + 4 = 29
    localparam logic [15:0] GPMC_IMPL_A = 16'hFFFF;
    localparam logic [15:0] GPMC_IMPL_B = 16'hB81F;
    localparam logic [15:0] GPMC_IMPL_C = 16'hE100;
endpackage

/* design/gpmc_pad.sv */
// One pad's direction, drive, pull and input sampling logic
`timescale 1ns/1ps
module gpmc_pad
    import gpmc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] mode,
    input wire logic drive_type_bit,
    input wire logic [1:0] pull_select_field,
    input wire logic out_val,
    input wire logic alt_out,
    input wire logic alt_oe,
    input wire logic pad_in,
    output logic pad_out_q,
    output logic pad_oe_q,
    output logic pu_en_q,
    output logic pd_en_q,
    output logic in_q
);
    wire is_out = (mode == GPMC_MODE_OUT);
    wire is_alt = (mode == GPMC_MODE_ALT);
    wire is_ana = (mode == GPMC_MODE_ANA);
    // Driver active in output mode, or alt mode with peripheral enable
    wire drv = is_out | (is_alt & alt_oe);
    wire data = is_alt ? alt_out : out_val;
    // Open-drain only ever drives low
    wire oe_d = drv & (~drive_type_bit | ~data);
    wire pu_d = ~is_ana & (pull_select_field == GPMC_PULL_UP);
    wire pd_d = ~is_ana & (pull_select_field == GPMC_PULL_DOWN);
    // Analog disables the input trigger, status reads zero
    wire in_d = ~is_ana & pad_in;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
            pu_en_q <= 1'b0;
            pd_en_q <= 1'b0;
            in_q <= 1'b0;
        end else begin
            pad_out_q <= data;
            pad_oe_q <= oe_d;
            pu_en_q <= pu_d;
            pd_en_q <= pd_d;
            in_q <= in_d;
        end
    end
endmodule

/* design/gpmc_port.sv */
// Register set and up to sixteen pads of one port
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gpmc_port
    import gpmc_pkg::*;
#(
    parameter logic [31:0] MODE_RST = 32'h00000000,
    parameter logic [31:0] PULL_RST = 32'h00000000,
    parameter logic [15:0] IMPL = 16'hFFFF
)(
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [9:0] wr_off,
    input wire logic [31:0] wr_data,
    input wire logic [9:0] rd_off,
    output logic [31:0] rd_data,
    output logic rd_hit,
    input wire logic [15:0] alt_out,
    input wire logic [15:0] alt_oe,
    input wire logic [15:0] pad_in,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe,
    output logic [15:0] pu_en,
    output logic [15:0] pd_en,
    output logic [31:0] speed,
    output logic [15:0] line_level
);
    logic [31:0] mode_q;
    logic [15:0] drive_q;
    logic [31:0] speed_q;
    logic [31:0] pull_q;
    logic [15:0] out_q;
    logic [15:0] in_stat;
    logic [15:0] out_d;

    // A port with no pins would leave every pad output tied off
    if (IMPL == 16'h0000) begin : g_bad_impl
        $error("port has no implemented pins");
    end

    wire [15:0] imsk = IMPL;
    wire [31:0] imsk2;
    for (genvar g = 0; g < GPMC_PINS; g++) begin : g_msk
        assign imsk2[2*g +: 2] = {2{IMPL[g]}};
    end

    wire w_mode = wr_en && (wr_off == GPMC_OFF_MODE);
    wire w_drive = wr_en && (wr_off == GPMC_OFF_DRIVE);
    wire w_speed = wr_en && (wr_off == GPMC_OFF_SPEED);
    wire w_pull = wr_en && (wr_off == GPMC_OFF_PULL);
    wire w_out = wr_en && (wr_off == GPMC_OFF_OUTPUT);
    wire w_sc = wr_en && (wr_off == GPMC_OFF_SETCLR);
    wire w_tg = wr_en && (wr_off == GPMC_OFF_TOGGLE);

    // Set wins over clear in the set/clear word, as software expects
    wire [15:0] sc_val = (out_q & ~wr_data[31:16]) | wr_data[15:0];
    assign out_d = w_out ? (wr_data[15:0] & imsk) :
                   w_sc ? (sc_val & imsk) :
                   w_tg ? ((out_q ^ wr_data[15:0]) & imsk) : out_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_q <= MODE_RST;
            drive_q <= 16'h0000;
            speed_q <= 32'h00000000;
            pull_q <= PULL_RST;
            out_q <= 16'h0000;
        end else begin
            if (w_mode) mode_q <= wr_data & imsk2;
            if (w_drive) drive_q <= wr_data[15:0] & imsk;
            if (w_speed) speed_q <= wr_data & imsk2;
            if (w_pull) pull_q <= wr_data & imsk2;
            out_q <= out_d;
        end
    end

    assign rd_hit = (rd_off == GPMC_OFF_MODE) || (rd_off == GPMC_OFF_DRIVE) ||
                    (rd_off == GPMC_OFF_SPEED) || (rd_off == GPMC_OFF_PULL) ||
                    (rd_off == GPMC_OFF_INPUT) || (rd_off == GPMC_OFF_OUTPUT) ||
                    (rd_off == GPMC_OFF_SETCLR) || (rd_off == GPMC_OFF_TOGGLE);
    assign rd_data = (rd_off == GPMC_OFF_MODE) ? mode_q :
                     (rd_off == GPMC_OFF_DRIVE) ? {16'h0000, drive_q} :
                     (rd_off == GPMC_OFF_SPEED) ? speed_q :
                     (rd_off == GPMC_OFF_PULL) ? pull_q :
                     (rd_off == GPMC_OFF_INPUT) ? {16'h0000, in_stat} :
                     (rd_off == GPMC_OFF_OUTPUT) ? {16'h0000, out_q} : 32'h00000000;

    // Speed is handed to the pad cells as stored; they apply it when driving
    assign speed = speed_q;
    assign line_level = in_stat;

    for (genvar p = 0; p < GPMC_PINS; p++) begin : g_pad
        if (IMPL[p]) begin : g_impl
            gpmc_pad u_pad (
                .clock(clock),
                .nrst(nrst),
                .mode(mode_q[2*p +: 2]),
                .drive_type_bit(drive_q[p]),
                .pull_select_field(pull_q[2*p +: 2]),
                .out_val(out_q[p]),
                .alt_out(alt_out[p]),
                .alt_oe(alt_oe[p]),
                .pad_in(pad_in[p]),
                .pad_out_q(pad_out[p]),
                .pad_oe_q(pad_oe[p]),
                .pu_en_q(pu_en[p]),
                .pd_en_q(pd_en[p]),
                .in_q(in_stat[p])
            );
        end else begin : g_none
            assign pad_out[p] = 1'b0;
            assign pad_oe[p] = 1'b0;
            assign pu_en[p] = 1'b0;
            assign pd_en[p] = 1'b0;
            assign in_stat[p] = 1'b0;
        end
    end
endmodule

/* design/gpmc_top.sv */
// Top of the three-port GPIO block with its APB slave
`timescale 1ns/1ps
module gpmc_top
    import gpmc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [47:0] alt_out,
    input wire logic [47:0] alt_oe,
    input wire logic [47:0] pad_in,
    output logic [47:0] pad_out,
    output logic [47:0] pad_oe,
    output logic [47:0] pu_en,
    output logic [47:0] pd_en,
    output logic [95:0] speed,
    output logic [47:0] line_level
);
    // ----------------------------------------------------------------
    // APB slave: one wait state, so the answer leaves flip-flops
    // ----------------------------------------------------------------
    wire [1:0] port_sel = paddr[11:GPMC_PORT_SEL_LSB];
    wire [9:0] off = paddr[9:0];
    wire access = psel & penable;
    logic [31:0] rd_p [GPMC_PORTS];
    logic [GPMC_PORTS-1:0] hit_p;
    wire port_ok = (port_sel < 2'h3);
    wire hit = port_ok && hit_p[port_sel];
    logic [31:0] rdata_sel;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    assign rdata_sel = port_ok ? rd_p[port_sel] : 32'h00000000;
    // First access cycle decodes, second answers; a write lands with the answer
    wire answer_d = access & ~pready_q;
    wire commit = access & pready_q;
    wire [31:0] prdata_d = (answer_d && !pwrite && hit) ? rdata_sel : 32'h00000000;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= answer_d;
            pslverr_q <= answer_d & ~hit;
            prdata_q <= prdata_d;
        end
    end
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ----------------------------------------------------------------
    // Ports
    // ----------------------------------------------------------------
    localparam logic [31:0] MR [GPMC_PORTS] = '{GPMC_MODE_RST_A, GPMC_MODE_RST_B,
                                                 GPMC_MODE_RST_C};
    localparam logic [31:0] PR [GPMC_PORTS] = '{GPMC_PULL_RST_A, GPMC_PULL_RST_B,
                                                 GPMC_PULL_RST_C};
    localparam logic [15:0] IM [GPMC_PORTS] = '{GPMC_IMPL_A, GPMC_IMPL_B, GPMC_IMPL_C};

    for (genvar k = 0; k < GPMC_PORTS; k++) begin : g_port
        gpmc_port #(
            .MODE_RST(MR[k]),
            .PULL_RST(PR[k]),
            .IMPL(IM[k])
        ) u_port (
            .clock(clock),
            .nrst(nrst),
            .wr_en(commit && pwrite && port_ok && (port_sel == 2'(k))),
            .wr_off(off),
            .wr_data(pwdata),
            .rd_off(off),
            .rd_data(rd_p[k]),
            .rd_hit(hit_p[k]),
            .alt_out(alt_out[16*k +: 16]),
            .alt_oe(alt_oe[16*k +: 16]),
            .pad_in(pad_in[16*k +: 16]),
            .pad_out(pad_out[16*k +: 16]),
            .pad_oe(pad_oe[16*k +: 16]),
            .pu_en(pu_en[16*k +: 16]),
            .pd_en(pd_en[16*k +: 16]),
            .speed(speed[32*k +: 32]),
            .line_level(line_level[16*k +: 16])
        );
    end
endmodule

/* testbench/gpmc_assertions.sv */
// Concurrent checks on the APB slave and pin 0 of the first port
`timescale 1ns/1ps
module gpmc_assertions
    import gpmc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [47:0] alt_out,
    input wire logic [47:0] alt_oe,
    input wire logic [47:0] pad_in,
    input wire logic [47:0] pad_out,
    input wire logic [47:0] pad_oe,
    input wire logic [47:0] pu_en,
    input wire logic [47:0] pd_en,
    input wire logic [47:0] line_level
);
    // ----------------------------------------
    // Shadow of pin 0 setup, seen from the bus
    // ----------------------------------------
    logic [1:0] m0_q;
    logic d0_q;
    logic [1:0] p0_q;
    wire wr_done = psel && penable && pwrite && pready;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            m0_q <= GPMC_MODE_RST_A[1:0];
            d0_q <= 1'b0;
            p0_q <= GPMC_PULL_RST_A[1:0];
        end else if (wr_done) begin
            if (paddr == 12'h000) m0_q <= pwdata[1:0];
            if (paddr == 12'h004) d0_q <= pwdata[0];
            if (paddr == 12'h00C) p0_q <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    chk_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("access phase not answered after one wait");
    chk_bad_port: assert property (psel && penable && pready && paddr[11:10] == 2'h3 |->
        pslverr)
        else $error("no error for missing port");
    chk_idle_read: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read access");
    chk_input_off: assert property (m0_q == GPMC_MODE_IN |=> !pad_oe[0])
        else $error("pad driven in input mode");
    chk_analog_quiet: assert property (m0_q == GPMC_MODE_ANA |=>
        !pad_oe[0] && !pu_en[0] && !pd_en[0] && !line_level[0])
        else $error("analog pin not quiet");
    chk_push_pull: assert property (m0_q == GPMC_MODE_OUT && !d0_q |=> pad_oe[0])
        else $error("push-pull output not driving");
    chk_open_drain: assert property (m0_q == GPMC_MODE_OUT && d0_q |=>
        pad_oe[0] == !pad_out[0])
        else $error("open-drain enable wrong");
    chk_alt_follow: assert property (m0_q == GPMC_MODE_ALT && !d0_q |=>
        pad_oe[0] == $past(alt_oe[0]) && pad_out[0] == $past(alt_out[0]))
        else $error("alternate pin not following peripheral");
    chk_pull_pick: assert property (m0_q != GPMC_MODE_ANA |=>
        pu_en[0] == ($past(p0_q) == GPMC_PULL_UP) && pd_en[0] == ($past(p0_q) == GPMC_PULL_DOWN))
        else $error("pull enables wrong");
    chk_line_sample: assert property (m0_q != GPMC_MODE_ANA |=>
        line_level[0] == $past(pad_in[0]))
        else $error("pin level not sampled");
endmodule
bind gpmc_top gpmc_assertions chk (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .alt_out, .alt_oe, .pad_in, .pad_out, .pad_oe, .pu_en,
    .pd_en, .line_level);

/* testbench/gpmc_pins.sv */
// Board-side model: resolves each pad from driver, pulls and a floating level
`timescale 1ns/1ps
module gpmc_pins (
    input wire logic clock,
    input wire logic [47:0] pad_out,
    input wire logic [47:0] pad_oe,
    input wire logic [47:0] pu_en,
    input wire logic [47:0] pd_en,
    output logic [47:0] pad_in
);
    // An unpulled, undriven pin wanders, so no test can lean on its level
    logic [47:0] flt_q = 48'h5555_5555_5555;
    always_ff @(posedge clock) flt_q <= ~flt_q;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pu_en | (~pd_en & flt_q)));
endmodule

/* testbench/tb_gpio_pad_mode_config.sv */
// Self-checking bench for the GPIO block over APB
`timescale 1ns/1ps
module tb_gpio_pad_mode_config;
    import gpmc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [47:0] alt_out = 48'h0;
    logic [47:0] alt_oe = 48'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [47:0] pad_in, pad_out, pad_oe, pu_en, pd_en, line_level;
    logic [95:0] speed;
    logic [15:0] oe_x[4] = '{16'h0, 16'hFFFF, 16'h0F0F, 16'h0};
    logic [15:0] lv_x[4] = '{16'hFFFF, 16'h00FF, 16'hF3F3, 16'h0};
    int miscompares = 0;
    int checks_done = 0;
    always #2.5 clock = ~clock;
    gpmc_top uut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .alt_out, .alt_oe, .pad_in, .pad_out, .pad_oe, .pu_en, .pd_en, .speed,
        .line_level);
    gpmc_pins pins (.clock, .pad_out, .pad_oe, .pu_en, .pd_en, .pad_in);
    task check(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // APB master: request held until pready
    // ----------------------------------------
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clock);
        if (n == 50) begin
            miscompares++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        check(48'(rd), 48'(exp));
        check(48'(err), 48'(e));
    endtask
    // Pads lag the stored write by one edge and line levels by two
    task settle;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rdchk(12'h000, GPMC_MODE_RST_A, 1'b0);
        rdchk(12'h400, GPMC_MODE_RST_B, 1'b0);
        rdchk(12'h00C, GPMC_PULL_RST_A, 1'b0);
        settle;
        check(pu_en, 48'h0000_0010_A000);
        check(pd_en, 48'h0000_0000_4000);
        check(pad_oe, 48'h0);
        $display("reset test done");
        apb(1'b1, 12'h014, 32'h00FF);
        apb(1'b1, 12'h00C, 32'h5555_5555);
        alt_oe <= 48'h0F0F;
        alt_out <= 48'h3333;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, {16{2'(i)}});
            settle;
            check(48'(pad_oe[15:0]), 48'(oe_x[i]));
            check(48'(line_level[15:0]), 48'(lv_x[i]));
            check(48'(pu_en[15:0]), (i == 3) ? 48'h0 : 48'hFFFF);
            rdchk(12'h010, {16'h0, lv_x[i]}, 1'b0);
        end
        $display("mode test done");
        apb(1'b1, 12'h000, 32'h5555_5555);
        apb(1'b1, 12'h004, 32'h0000_FFFF);
        settle;
        check(48'(pad_oe[15:0]), 48'hFF00);
        check(48'(line_level[15:0]), 48'h00FF);
        apb(1'b1, 12'h00C, 32'hAAAA_AAAA);
        apb(1'b1, 12'h008, 32'h1234_5678);
        settle;
        check(48'(pd_en[15:0]), 48'hFFFF);
        check(48'(line_level[15:0]), 48'h0);
        check(48'(speed[31:0]), 48'h1234_5678);
        $display("drive test done");
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h018, 32'h0007_0104);
        rdchk(12'h014, 32'h01FC, 1'b0);
        rdchk(12'h018, 32'h0, 1'b0);
        apb(1'b1, 12'h02C, 32'h000F);
        apb(1'b1, 12'h02C, 32'h00F0);
        rdchk(12'h014, 32'h0103, 1'b0);
        settle;
        check(48'(pad_out[15:0]), 48'h0103);
        $display("bit operate test done");
        apb(1'b1, 12'hC00, 32'hFFFF);
        check(48'(err), 48'h1);
        rdchk(12'hC00, 32'h0, 1'b1);
        rdchk(12'h020, 32'h0, 1'b1);
        apb(1'b1, 12'h414, 32'hFFFF);
        rdchk(12'h414, 32'hB81F, 1'b0);
        $display("map test done");
        results();
    end
endmodule
